// File: hw/sfcp_pkg.sv
// Shared constants and types for the serial flash command and protect block.
package sfcp_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int WSR_TIME_US = 15;
    localparam int WSR_CYCLES = WSR_TIME_US * (CLK_HZ / 1_000_000);
    localparam int AW = 19;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DOUT = 8'h3b;
    localparam logic [7:0] OP_DIO = 8'hbb;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE1 = 8'hc7;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_RDID = 8'hab;
    localparam logic [7:0] OP_MFID = 8'h90;
    localparam int SB_BUSY = 0;
    localparam int SB_WEL = 1;
    localparam int SB_BP_LO = 2;
    localparam int SB_BP_HI = 4;
    localparam int SB_TB = 5;
    localparam int SB_LOCK = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [19:0] ARRAY_END = 20'h7ffff;
    localparam logic [19:0] ARRAY_SIZE = 20'h80000;
    localparam logic [19:0] SZ_64K = 20'h10000;
    localparam logic [19:0] SZ_128K = 20'h20000;
    localparam logic [19:0] SZ_256K = 20'h40000;
    localparam int IN_D0 = 0;
    localparam int IN_D1 = 1;
    localparam int IN_WP = 2;
    localparam int IN_CLK = 3;
    localparam int IN_CS = 4;
    localparam int NIN = 5;
    localparam logic [4:0] SYNC_RESET = 5'h14;
    typedef enum logic [2:0] {
        CMD_PROG = 3'h0,
        CMD_SE = 3'h1,
        CMD_BE32 = 3'h2,
        CMD_BE64 = 3'h3,
        CMD_CE = 3'h4
    } sfcp_kind_t;
    typedef struct packed {
        sfcp_kind_t kind;
        logic [AW-1:0] addr;
    } sfcp_cmd_t;
endpackage : sfcp_pkg

// File: hw/sfcp_top.sv
// Serial flash instruction front end with status lock and array protection.
`timescale 1ns/1ps
module sfcp_top #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] DEVICE_CODE = 8'h3c,
    parameter int WSR_CYC = sfcp_pkg::WSR_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic wp_n,
    input wire logic dual_line_zero_in,
    output logic dual_line_zero_out,
    output logic dual_line_zero_oe,
    input wire logic dual_line_one_in,
    output logic dual_line_one_out,
    output logic dual_line_one_oe,
    output logic [sfcp_pkg::AW-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic [7:0] prog_data,
    output logic prog_data_valid,
    output sfcp_pkg::sfcp_cmd_t cmd,
    output logic cmd_go,
    output logic cmd_reject,
    input wire logic array_done,
    output logic [7:0] flash_status
);
    import sfcp_pkg::*;

    // Maker and device codes above are arbitrary values.
    typedef enum logic [5:0] {
        ST_WAIT = 6'b000001,
        ST_OPC = 6'b000010,
        ST_ADDR = 6'b000100,
        ST_DUMMY = 6'b001000,
        ST_DIN = 6'b010000,
        ST_DOUT = 6'b100000
    } sfcp_state_t;

    localparam int TW = $clog2(WSR_CYC + 1);

    function automatic logic is_addr_op(input logic [7:0] op);
        return op == OP_READ || op == OP_FAST || op == OP_DOUT || op == OP_DIO
            || op == OP_RDID || op == OP_MFID || op == OP_PROG || op == OP_SE
            || op == OP_BE32 || op == OP_BE64;
    endfunction : is_addr_op

    function automatic logic [AW-1:0] region_mask(input sfcp_kind_t k);
        case (k)
            CMD_PROG: return 19'h000ff;
            CMD_SE: return 19'h00fff;
            CMD_BE32: return 19'h07fff;
            CMD_BE64: return 19'h0ffff;
            default: return 19'h7ffff;
        endcase
    endfunction : region_mask

    // True when [lo, hi] overlaps the window chosen by range code and bottom select.
    function automatic logic prot_hit(input logic [19:0] lo, input logic [19:0] hi,
                                      input logic [2:0] bp, input logic tb);
        logic [19:0] sz;
        logic [19:0] plo;
        logic [19:0] phi;
        sz = bp[1] ? (bp[0] ? SZ_256K : SZ_128K) : SZ_64K;
        plo = tb ? 20'h00000 : ARRAY_SIZE - sz;
        phi = tb ? sz - 20'h00001 : ARRAY_END;
        if (bp[2])
        begin
            plo = 20'h00000;
            phi = ARRAY_END;
        end
        return bp != 3'b000 && lo <= phi && hi >= plo;
    endfunction : prot_hit

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree.
    logic [NIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [NIN-1:0] filt_next;
    wire [NIN-1:0] agree = ~(s2_reg ^ s3_reg);
    assign filt_next = (agree & s3_reg) | (~agree & filt_reg);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1_reg <= SYNC_RESET;
            s2_reg <= SYNC_RESET;
            s3_reg <= SYNC_RESET;
            filt_reg <= SYNC_RESET;
        end
        else
        begin
            s1_reg <= {cs_n, sclk, wp_n, dual_line_one_in, dual_line_zero_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    wire sel = ~filt_next[IN_CS];
    wire cs_fall = filt_reg[IN_CS] & ~filt_next[IN_CS];
    wire cs_rise = ~filt_reg[IN_CS] & filt_next[IN_CS];
    wire clk_rise = sel & ~filt_reg[IN_CLK] & filt_next[IN_CLK];
    wire clk_fall = sel & filt_reg[IN_CLK] & ~filt_next[IN_CLK];
    wire serial_in = filt_next[IN_D0];
    wire d1_in = filt_next[IN_D1];
    wire wp_hi = filt_reg[IN_WP];

    ////////////////////////////////////////////////////////////////////////////
    // Instruction framing.
    sfcp_state_t st_reg, opc_dest, addr_dest;
    logic [7:0] op_reg, sh_reg, wsd_reg;
    logic [31:0] adr_reg;
    logic [4:0] bcnt_reg;
    logic [2:0] tot_reg;
    logic got_reg;
    logic lock_reg, tb_reg, wel_reg, busy_reg, arr_reg;
    logic [2:0] bp_reg;
    logic [TW-1:0] wtim_reg;

    wire [7:0] sh_next = {sh_reg[6:0], serial_in};
    wire byte_end = bcnt_reg[2:0] == 3'h7;
    wire dual_in = op_reg == OP_DIO;
    wire dual_out = op_reg == OP_DOUT || op_reg == OP_DIO;
    wire addr_end = bcnt_reg == (dual_in ? 5'h0f : 5'h17);
    // Odd bits arrive on line one, even bits on line zero.
    wire [31:0] adr_next = dual_in ? {adr_reg[29:0], d1_in, serial_in}
                                   : {adr_reg[30:0], serial_in};
    wire is_erase = op_reg == OP_SE || op_reg == OP_BE32 || op_reg == OP_BE64
        || op_reg == OP_CE1 || op_reg == OP_CE2;
    wire bare_new = sh_next == OP_WREN || sh_next == OP_WRDI || sh_next == OP_WRSR
        || sh_next == OP_CE1 || sh_next == OP_CE2;

    assign opc_dest = (busy_reg && sh_next != OP_RDSR) ? ST_WAIT :
                      (sh_next == OP_RDSR) ? ST_DOUT :
                      bare_new ? ST_DIN :
                      is_addr_op(sh_next) ? ST_ADDR : ST_WAIT;
    assign addr_dest = (op_reg == OP_FAST || op_reg == OP_DOUT) ? ST_DUMMY :
                       (op_reg == OP_PROG || is_erase) ? ST_DIN : ST_DOUT;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_reg <= ST_WAIT;
            op_reg <= 8'h00;
            sh_reg <= 8'h00;
            adr_reg <= 32'h00000000;
            bcnt_reg <= 5'h00;
            tot_reg <= 3'h0;
            got_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            st_reg <= ST_OPC;
            bcnt_reg <= 5'h00;
            tot_reg <= 3'h0;
            got_reg <= 1'b0;
        end
        else if (cs_rise)
            st_reg <= ST_WAIT;
        else if (clk_rise)
        begin
            tot_reg <= tot_reg + 3'h1;
            bcnt_reg <= bcnt_reg + 5'h01;
            case (st_reg)
                ST_OPC:
                begin
                    sh_reg <= sh_next;
                    if (byte_end)
                    begin
                        op_reg <= sh_next;
                        st_reg <= opc_dest;
                        bcnt_reg <= 5'h00;
                    end
                end
                ST_ADDR:
                begin
                    adr_reg <= adr_next;
                    if (addr_end)
                    begin
                        st_reg <= addr_dest;
                        bcnt_reg <= 5'h00;
                    end
                end
                ST_DUMMY:
                    if (byte_end)
                        st_reg <= ST_DOUT;
                ST_DIN:
                begin
                    sh_reg <= sh_next;
                    if (byte_end)
                        got_reg <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: one byte per eight falls, or per four in dual mode.
    logic [7:0] osh_reg;
    logic [2:0] ocnt_reg;
    logic tog_reg, l0_reg, l1_reg, oe0_reg, oe1_reg;
    logic [7:0] stat_byte;

    always_comb
    begin
        stat_byte = 8'h00;
        stat_byte[SB_LOCK] = lock_reg;
        stat_byte[SB_TB] = tb_reg;
        stat_byte[SB_BP_HI:SB_BP_LO] = bp_reg;
        stat_byte[SB_WEL] = wel_reg;
        stat_byte[SB_BUSY] = busy_reg;
    end

    wire mem_src = op_reg == OP_READ || op_reg == OP_FAST || dual_out;
    wire oload = ocnt_reg == 3'h0;
    // Status is resampled at every byte so a polling host sees busy drop.
    wire [7:0] osrc = (op_reg == OP_RDSR) ? stat_byte :
                      (op_reg == OP_RDID) ? DEVICE_CODE :
                      (op_reg == OP_MFID) ? (tog_reg ? DEVICE_CODE : MAKER_CODE) :
                      mem_rdata;
    wire [7:0] obyte = oload ? osrc : osh_reg;
    wire ofall = clk_fall && st_reg == ST_DOUT;

    always_ff @(posedge sys_clk)
    begin
        if (srst || cs_fall || cs_rise)
        begin
            osh_reg <= 8'h00;
            ocnt_reg <= 3'h0;
            tog_reg <= 1'b0;
            l0_reg <= 1'b0;
            l1_reg <= 1'b0;
            oe0_reg <= 1'b0;
            oe1_reg <= 1'b0;
        end
        else if (ofall)
        begin
            l1_reg <= obyte[7];
            l0_reg <= obyte[6];
            osh_reg <= dual_out ? {obyte[5:0], 2'b00} : {obyte[6:0], 1'b0};
            ocnt_reg <= (ocnt_reg == (dual_out ? 3'h3 : 3'h7)) ? 3'h0 : ocnt_reg + 3'h1;
            oe1_reg <= 1'b1;
            oe0_reg <= dual_out;
            if (oload)
                tog_reg <= ~tog_reg;
        end
    end

    assign dual_line_zero_out = l0_reg;
    assign dual_line_zero_oe = oe0_reg;
    assign dual_line_one_out = l1_reg;
    assign dual_line_one_oe = oe1_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Array address, program byte strobe and first status data byte.
    logic [AW-1:0] addr_reg;
    logic [7:0] pd_reg;
    logic pdv_reg;
    wire din_byte = clk_rise && st_reg == ST_DIN && byte_end;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            addr_reg <= '0;
            pd_reg <= 8'h00;
            pdv_reg <= 1'b0;
            wsd_reg <= 8'h00;
        end
        else
        begin
            pdv_reg <= din_byte && op_reg == OP_PROG;
            if (clk_rise && st_reg == ST_ADDR && addr_end)
                addr_reg <= dual_in ? adr_next[26:8] : adr_next[18:0];
            else if (ofall && oload && mem_src)
                addr_reg <= addr_reg + 19'h00001;
            else if (pdv_reg)
                addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
            if (din_byte)
                pd_reg <= sh_next;
            if (din_byte && !got_reg)
                wsd_reg <= sh_next;
        end
    end

    assign mem_addr = addr_reg;
    assign prog_data = pd_reg;
    assign prog_data_valid = pdv_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Commit on deselect, protection and busy tracking.
    sfcp_kind_t kind;
    assign kind = (op_reg == OP_PROG) ? CMD_PROG : (op_reg == OP_SE) ? CMD_SE :
                  (op_reg == OP_BE32) ? CMD_BE32 : (op_reg == OP_BE64) ? CMD_BE64 : CMD_CE;
    wire [AW-1:0] rmask = region_mask(kind);
    wire [AW-1:0] rlo = addr_reg & ~rmask;
    wire hit = prot_hit({1'b0, rlo}, {1'b0, rlo | rmask}, bp_reg, tb_reg);

    wire commit = cs_rise && st_reg == ST_DIN && tot_reg == 3'h0 && !busy_reg;
    wire wsr_ok = ~(lock_reg & ~wp_hi);
    wire do_wren = commit && op_reg == OP_WREN;
    wire do_wrdi = commit && op_reg == OP_WRDI;
    wire wsr_go = commit && op_reg == OP_WRSR && got_reg && wel_reg && wsr_ok;
    wire arr_req = commit && wel_reg && (op_reg == OP_PROG ? got_reg : is_erase);
    wire go_w = arr_req && !hit;
    wire rej_w = arr_req && hit;
    wire done = busy_reg && (arr_reg ? array_done : wtim_reg == '0);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lock_reg <= STATUS_RESET[SB_LOCK];
            tb_reg <= STATUS_RESET[SB_TB];
            bp_reg <= STATUS_RESET[SB_BP_HI:SB_BP_LO];
            wel_reg <= 1'b0;
            busy_reg <= 1'b0;
            arr_reg <= 1'b0;
            wtim_reg <= '0;
            cmd_go <= 1'b0;
            cmd_reject <= 1'b0;
            cmd <= '0;
        end
        else
        begin
            cmd_go <= go_w;
            cmd_reject <= rej_w;
            if (go_w)
                cmd <= '{kind: kind, addr: rlo};
            if (wsr_go)
            begin
                lock_reg <= wsd_reg[SB_LOCK];
                tb_reg <= wsd_reg[SB_TB];
                bp_reg <= wsd_reg[SB_BP_HI:SB_BP_LO];
                busy_reg <= 1'b1;
                wtim_reg <= TW'(WSR_CYC - 1);
            end
            else if (go_w)
            begin
                busy_reg <= 1'b1;
                arr_reg <= 1'b1;
            end
            else if (done)
            begin
                busy_reg <= 1'b0;
                arr_reg <= 1'b0;
                wel_reg <= 1'b0;
            end
            else if (busy_reg)
                wtim_reg <= wtim_reg - TW'(1);
            if (do_wren)
                wel_reg <= 1'b1;
            else if (do_wrdi)
                wel_reg <= 1'b0;
        end
    end

    assign flash_status = stat_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_rsv_zero: assert property (@(posedge sys_clk) disable iff (srst)
        flash_status[6] == 1'b0) else $error("reserved status bit not zero");
    a_lock_refuse: assert property (@(posedge sys_clk) disable iff (srst)
        wsr_go |-> !(lock_reg && !wp_hi)) else $error("locked status write taken");
    a_wsr_latch: assert property (@(posedge sys_clk) disable iff (srst)
        wsr_go |=> busy_reg && flash_status[SB_WEL]) else $error("status write without latch");
    a_busy_ignore: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_rise && st_reg == ST_OPC && byte_end && busy_reg && sh_next != OP_RDSR)
        |=> st_reg == ST_WAIT) else $error("instruction taken while busy");
    a_cs_close: assert property (@(posedge sys_clk) disable iff (srst)
        cs_rise |=> st_reg == ST_WAIT && !dual_line_one_oe && !dual_line_zero_oe)
        else $error("deselect did not close instruction");
    a_cs_start: assert property (@(posedge sys_clk) disable iff (srst)
        cs_fall |=> st_reg == ST_OPC && bcnt_reg == 5'h00) else $error("no fresh opcode");
    a_go_protect: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(cmd_go) |-> !$past(hit) && !cmd_reject) else $error("protected region issued");
    a_byte_bound: assert property (@(posedge sys_clk) disable iff (srst)
        (go_w || wsr_go) |-> tot_reg == 3'h0) else $error("write off byte boundary");
    a_done_wel: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(busy_reg) |-> !wel_reg) else $error("latch kept after completion");
    a_wsr_busy: assert property (@(posedge sys_clk) disable iff (srst)
        wsr_go |=> busy_reg [*8]) else $error("status write cycle too short");

endmodule : sfcp_top

// File: verification/sfcp_host_model.sv
// SPI host model that frames instructions and shifts bytes in mode 0.
`timescale 1ns/1ps
module sfcp_host_model (
    input wire logic sys_clk,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic line0,
    input wire logic line1
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk
    task automatic sel();
        cs_n <= 1'b0;
        wait_clk(4);
    endtask : sel
    // Rising only after a full byte is the host's duty for write instructions.
    task automatic desel();
        wait_clk(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        wait_clk(8);
    endtask : desel
    // Bits are sampled just before the falling edge, which gives the device's
    // output a full clock phase to settle after it changed.
    task automatic xfer(input logic [7:0] tx, input int nbits, input bit dual,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i -= (dual ? 2 : 1))
        begin
            mosi <= tx[i];
            wait_clk(4);
            sclk <= 1'b1;
            wait_clk(4);
            rx = dual ? {rx[5:0], line1, line0} : {rx[6:0], line1};
            sclk <= 1'b0;
        end
    endtask : xfer
endmodule : sfcp_host_model

// File: verification/tb_sfcp_top.sv
// Self-checking bench for the serial flash command and protect block.
`timescale 1ns/1ps
module tb_sfcp_top;
    import sfcp_pkg::*;
    localparam logic [7:0] MC = 8'h5a; // Arbitrary maker code.
    localparam logic [7:0] DC = 8'h3c; // Arbitrary device code.
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic wp_n = 1'b1;
    logic array_done = 1'b0;
    logic go_seen = 1'b0;
    logic rej_seen = 1'b0;
    logic saw_oe = 1'b0;
    logic [7:0] pd_seen = 8'h00;
    logic cs_n, sclk, mosi, o0, o0e, o1, o1e, prog_data_valid, cmd_go, cmd_reject;
    logic [AW-1:0] mem_addr;
    logic [7:0] prog_data, flash_status, rx;
    logic [15:0] d;
    sfcp_cmd_t cmd;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    wire logic l0 = o0e ? o0 : mosi;
    // A released line shows the inverse of its last value so stale data cannot pass.
    wire logic l1 = o1e ? o1 : ~o1;
    wire logic [7:0] rdata = mem_addr[7:0] ^ 8'h96;
    always #25 sys_clk = ~sys_clk;
    // The array finishes one cycle after each accepted command.
    always @(posedge sys_clk)
    begin
        cyc++;
        array_done <= cmd_go;
        if (cmd_go) go_seen <= 1'b1;
        if (cmd_reject) rej_seen <= 1'b1;
        if (o0e | o1e) saw_oe <= 1'b1;
        if (prog_data_valid) pd_seen <= prog_data;
        if (cyc == 60000)
        begin
            failures++;
            report_and_stop();
        end
    end
    sfcp_top #(.MAKER_CODE(MC), .DEVICE_CODE(DC), .WSR_CYC(600)) dut_u (
        .sys_clk(sys_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .wp_n(wp_n),
        .dual_line_zero_in(l0), .dual_line_zero_out(o0), .dual_line_zero_oe(o0e),
        .dual_line_one_in(l1), .dual_line_one_out(o1), .dual_line_one_oe(o1e),
        .mem_addr(mem_addr), .mem_rdata(rdata), .prog_data(prog_data),
        .prog_data_valid(prog_data_valid), .cmd(cmd), .cmd_go(cmd_go),
        .cmd_reject(cmd_reject), .array_done(array_done), .flash_status(flash_status)
    );
    sfcp_host_model host_u (
        .sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .line0(l0), .line1(l1)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic send(input logic [7:0] op, input int n, input logic [23:0] a);
        host_u.sel();
        host_u.xfer(op, 8, 1'b0, rx);
        for (int i = 0; i < n; i++)
            host_u.xfer(a[23-8*i -: 8], 8, 1'b0, rx);
    endtask : send
    task automatic wait_ready();
        for (int k = 0; k < 2000 && flash_status[SB_BUSY] !== 1'b0; k++)
            @(posedge sys_clk);
    endtask : wait_ready
    task automatic wrsr(input logic [7:0] v);
        send(OP_WREN, 0, 24'h0);
        host_u.desel();
        send(OP_WRSR, 1, {v, 16'h0});
        host_u.desel();
        wait_ready();
    endtask : wrsr
    task automatic rd2(input logic [7:0] op, input logic [23:0] a, input int nd,
                       input bit dual);
        send(op, 3, a);
        repeat (nd) host_u.xfer(8'h00, 8, 1'b0, rx);
        host_u.xfer(8'h00, 8, dual, d[15:8]);
        host_u.xfer(8'h00, 8, dual, d[7:0]);
        host_u.desel();
    endtask : rd2
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_busy_and_lock();
        send(OP_WREN, 0, 24'h0);
        host_u.desel();
        send(OP_WRSR, 1, 24'h800000);
        host_u.desel();
        send(OP_RDSR, 0, 24'h0);
        host_u.xfer(8'h00, 8, 1'b0, rx);
        host_u.desel();
        check("busy status", 8'h83, rx);
        saw_oe <= 1'b0;
        rd2(OP_MFID, 24'h0, 0, 1'b0);
        check("output while busy", 8'h00, {7'h00, saw_oe});
        wait_ready();
        check("status after write", 8'h80, flash_status);
        wp_n <= 1'b0;
        wrsr(8'h00);
        check("locked write", 8'h82, flash_status);
        wp_n <= 1'b1;
        wrsr(8'h00);
        check("unlocked write", 8'h00, flash_status);
        wp_n <= 1'b0;
        wrsr(8'h7c);
        check("free write", 8'h3c, flash_status);
        send(OP_WREN, 0, 24'h0);
        host_u.desel();
        send(OP_WRSR, 0, 24'h0);
        host_u.xfer(8'h00, 5, 1'b0, rx);
        host_u.desel();
        wait_ready();
        check("partial write", 8'h3e, flash_status);
        wrsr(8'h00);
        wp_n <= 1'b1;
    endtask : t_busy_and_lock
    task automatic t_protect();
        logic [32:0] tbl [10] = '{{8'h04, 24'h070000, 1'b1}, {8'h04, 24'h06f000, 1'b0},
            {8'h08, 24'h060000, 1'b1}, {8'h0c, 24'h03f000, 1'b0}, {8'h24, 24'h00f000, 1'b1},
            {8'h28, 24'h020000, 1'b0}, {8'h2c, 24'h03f000, 1'b1}, {8'h10, 24'h000000, 1'b1},
            {8'h30, 24'h07f000, 1'b1}, {8'h20, 24'h000000, 1'b0}};
        foreach (tbl[i])
        begin
            wrsr(tbl[i][32:25]);
            send(OP_WREN, 0, 24'h0);
            host_u.desel();
            go_seen <= 1'b0;
            rej_seen <= 1'b0;
            send(OP_SE, 3, tbl[i][24:1]);
            host_u.desel();
            check("protect hit", {6'h00, ~tbl[i][0], tbl[i][0]},
                  {6'h00, go_seen, rej_seen});
            if (go_seen === 1'b1)
            begin
                check("erase kind", {5'h00, CMD_SE}, {5'h00, cmd.kind});
                check("erase base", tbl[i][19:12], cmd.addr[18:11]);
            end
            wait_ready();
        end
        wrsr(8'h00);
    endtask : t_protect
    task automatic t_prog();
        send(OP_WREN, 0, 24'h0);
        host_u.desel();
        go_seen <= 1'b0;
        send(OP_PROG, 3, 24'h000100);
        host_u.xfer(8'ha5, 8, 1'b0, rx);
        host_u.desel();
        check("program byte", 8'ha5, pd_seen);
        check("program go", 8'h01, {7'h00, go_seen});
        check("program base", 8'h01, cmd.addr[15:8]);
        wait_ready();
        check("status after program", 8'h00, flash_status);
    endtask : t_prog
    task automatic t_reads();
        send(OP_READ, 3, 24'h001234);
        host_u.xfer(8'h00, 8, 1'b0, rx);
        check("read data", 8'h34 ^ 8'h96, rx);
        host_u.xfer(8'h00, 3, 1'b0, rx);
        host_u.desel();
        check("released oe", 8'h00, {6'h00, o0e, o1e});
        send(OP_RDSR, 0, 24'h0);
        host_u.xfer(8'h00, 8, 1'b0, d[15:8]);
        host_u.xfer(8'h00, 8, 1'b0, d[7:0]);
        host_u.desel();
        check("status repeat", 8'h00, d[15:8] | d[7:0]);
        rd2(OP_FAST, 24'h0020ff, 1, 1'b0);
        check("fast first", 8'hff ^ 8'h96, d[15:8]);
        check("fast next", 8'h00 ^ 8'h96, d[7:0]);
        rd2(OP_DOUT, 24'h000010, 1, 1'b1);
        check("dual first", 8'h10 ^ 8'h96, d[15:8]);
        check("dual next", 8'h11 ^ 8'h96, d[7:0]);
        rd2(OP_RDID, 24'h0, 0, 1'b0);
        check("device code", DC, d[15:8]);
        check("device repeat", DC, d[7:0]);
        rd2(OP_MFID, 24'h0, 0, 1'b0);
        check("maker code", MC, d[15:8]);
        check("device after maker", DC, d[7:0]);
    endtask : t_reads
    initial
    begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("reset status", 8'h00, flash_status);
        t_busy_and_lock();
        t_protect();
        t_prog();
        t_reads();
        report_and_stop();
    end
endmodule : tb_sfcp_top
